// file: inc/lfc_pkg.sv
// Shared constants and types for the flash driver configuration registers
package lfc_pkg;

	// Register addresses on the serial register port
	localparam logic [7:0] ADDR_SUPPLY_MON = 8'h80;
	localparam logic [7:0] ADDR_LAST_FLASH = 8'h81;
	localparam logic [7:0] ADDR_TORCH = 8'ha0;
	localparam logic [7:0] ADDR_FLASH = 8'hb0;
	localparam logic [7:0] ADDR_FLAGS = 8'hd0;

	// Supply monitor register fields
	localparam int SM_EN_BIT = 0;
	localparam int SM_TH_LSB = 1;
	localparam int SM_FEN_BIT = 3;
	localparam int SM_FTH_LSB = 4;
	localparam int TH_W = 2;
	localparam logic [7:0] SUPPLY_MON_MASK = 8'h3f;
	localparam logic [7:0] SUPPLY_MON_RST = 8'h00;

	// Torch register fields
	localparam int TORCH_W = 3;
	localparam int TORCH1_LSB = 0;
	localparam int TORCH2_LSB = 3;
	localparam logic [2:0] TORCH_CODE_RST = 3'h2;

	// Flash register fields, shared by the capture register
	localparam int FLASH_W = 4;
	localparam int FLASH1_LSB = 0;
	localparam int FLASH2_LSB = 4;
	localparam logic [3:0] FLASH_CODE_RST = 4'hd;
	localparam logic [7:0] LAST_FLASH_RST = 8'h00;
	localparam logic [7:0] RDATA_ZERO = 8'h00;

	// Fault flag positions inside the flag vector
	localparam int FLAG_NTC = 0;
	localparam int FLAG_VMON = 1;
	localparam int FLAG_VFLASH = 2;
	localparam int NUM_FLAGS = 3;

	// Timing: clock rate and documented delays
	localparam int CLK_MHZ = 200;
	localparam int TRIP_DELAY_US = 250;
	localparam int DEGLITCH_US = 8;
	localparam int TRIP_DELAY_CYC = TRIP_DELAY_US * CLK_MHZ;
	localparam int DEGLITCH_CYC = DEGLITCH_US * CLK_MHZ;

	// Trip qualifier states
	typedef enum logic [1:0] {QS_IDLE, QS_COUNT, QS_HELD} lfc_qual_state_t;

endpackage

// file: logic/lfc_config_regs.sv
// Supply monitor, capture and LED current registers of the flash driver
//
// What this block does
// - Supply register bits 2:1 pick monitor threshold 2.9/3.0/3.1/3.2 V.
// - Flash-time monitor runs only while supply register bit 3 is set.
// - Bits 5:4 pick flash-time threshold, same coding; bits 7:6 unused.
// - Read-only capture register: LED1 flash code low nibble, LED2 high.
// - Thermistor trip in thermistor mode loads the capture register.
// - Supply monitor trip while enabled loads the capture register.
// - Flash-time monitor trip while enabled loads the capture register.
// - Capture is written in the same cycle its fault flag is set.
// - Thermistor and supply monitor trips act 250 us after crossing.
// - Flash-time monitor acts only after 8 us continuously below.
// - LED1 torch code is torch register bits 2:0, 31.25 mA steps.
// - LED2 torch code is torch register bits 5:3; bits 7:6 unused.
// - LED1 flash code is flash register bits 3:0, 62.5 mA steps.
// - LED2 flash code is flash register bits 7:4, same steps.
// - Both flash codes reset to 1101, 875 mA each.
// - Reading the flags register clears all fault flags not set in the same cycle.
`timescale 1ns/1ps
module lfc_config_regs #(
	parameter int TRIP_DELAY_CYC = lfc_pkg::TRIP_DELAY_CYC,
	parameter int DEGLITCH_CYC = lfc_pkg::DEGLITCH_CYC,
	parameter int CNT_W = 16
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	// Register port from the serial interface decoder
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rd_ack,
	output logic reg_hit,
	// Comparator levels and mode inputs
	input wire logic thermistor_sense_pin,
	input wire logic ntc_mode_en,
	input wire logic supply_below_mon,
	input wire logic supply_below_flash,
	// Monitor controls toward the analog side
	output logic supply_mon_en,
	output logic [1:0] supply_monitor_level,
	output logic flash_mon_en,
	output logic [1:0] flash_monitor_level,
	// LED current codes
	output logic [2:0] led1_torch_code,
	output logic [2:0] led2_torch_code,
	output logic [3:0] led1_flash_code,
	output logic [3:0] led2_flash_code,
	// Capture register and fault flags toward the flags register
	output logic [7:0] last_flash_capture,
	output logic [2:0] fault_flags,
	output logic flag_write
);
	logic [7:0] supply_monitor_config_reg;
	logic [5:0] torch_current_select_reg;
	logic [7:0] flash_current_select_reg;
	logic [7:0] last_flash_capture_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic hit_reg;
	logic hit_next;
	logic ack_reg;
	logic [2:0] trip_set;
	logic trip_any;
	logic flags_clr;
	logic flag_write_reg;
	logic ntc_arm;
	logic vmon_arm;
	logic vflash_arm;
	logic wr_supply;
	logic wr_torch;
	logic wr_flash;

	// Refuse parameter values the qualifier counters cannot serve
	initial begin
		if (TRIP_DELAY_CYC < 1 || TRIP_DELAY_CYC > (2 ** CNT_W)) begin
			$error("lfc_config_regs: TRIP_DELAY_CYC out of range");
		end
		if (DEGLITCH_CYC < 1 || DEGLITCH_CYC > (2 ** CNT_W)) begin
			$error("lfc_config_regs: DEGLITCH_CYC out of range");
		end
	end

	// Write decode; the capture address has no write strobe at all
	assign wr_supply = reg_wr && (reg_addr == lfc_pkg::ADDR_SUPPLY_MON);
	assign wr_torch = reg_wr && (reg_addr == lfc_pkg::ADDR_TORCH);
	assign wr_flash = reg_wr && (reg_addr == lfc_pkg::ADDR_FLASH);

	// Supply monitor configuration; unused top bits are never stored
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			supply_monitor_config_reg <= lfc_pkg::SUPPLY_MON_RST;
		end else if (wr_supply) begin
			supply_monitor_config_reg <= reg_wdata & lfc_pkg::SUPPLY_MON_MASK;
		end
	end

	// Torch currents, two three-bit codes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			torch_current_select_reg <= {lfc_pkg::TORCH_CODE_RST, lfc_pkg::TORCH_CODE_RST};
		end else if (wr_torch) begin
			torch_current_select_reg <= reg_wdata[5:0];
		end
	end

	// Flash currents, both fields come up at 875 mA
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			flash_current_select_reg <= {lfc_pkg::FLASH_CODE_RST, lfc_pkg::FLASH_CODE_RST};
		end else if (wr_flash) begin
			flash_current_select_reg <= reg_wdata;
		end
	end

	// Monitor enables and threshold codes to the comparators
	assign supply_mon_en = supply_monitor_config_reg[lfc_pkg::SM_EN_BIT];
	assign supply_monitor_level =
		supply_monitor_config_reg[lfc_pkg::SM_TH_LSB +: lfc_pkg::TH_W];
	assign flash_mon_en = supply_monitor_config_reg[lfc_pkg::SM_FEN_BIT];
	assign flash_monitor_level =
		supply_monitor_config_reg[lfc_pkg::SM_FTH_LSB +: lfc_pkg::TH_W];

	// LED current codes straight from their fields
	assign led1_torch_code =
		torch_current_select_reg[lfc_pkg::TORCH1_LSB +: lfc_pkg::TORCH_W];
	assign led2_torch_code =
		torch_current_select_reg[lfc_pkg::TORCH2_LSB +: lfc_pkg::TORCH_W];
	assign led1_flash_code =
		flash_current_select_reg[lfc_pkg::FLASH1_LSB +: lfc_pkg::FLASH_W];
	assign led2_flash_code =
		flash_current_select_reg[lfc_pkg::FLASH2_LSB +: lfc_pkg::FLASH_W];

	// Each source is armed only by its own mode bit; disarming restarts the count
	assign ntc_arm = ntc_mode_en;
	assign vmon_arm = supply_mon_en;
	assign vflash_arm = flash_mon_en;

	// Thermistor trip, delayed like the supply monitor
	lfc_trip_qualify #(
		.CNT_W(CNT_W),
		.HOLD_CYC(TRIP_DELAY_CYC)
	) u_ntc_qual (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.arm(ntc_arm),
		.below(thermistor_sense_pin),
		.trip(trip_set[lfc_pkg::FLAG_NTC])
	);

	// Plain supply monitor trip
	lfc_trip_qualify #(
		.CNT_W(CNT_W),
		.HOLD_CYC(TRIP_DELAY_CYC)
	) u_vmon_qual (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.arm(vmon_arm),
		.below(supply_below_mon),
		.trip(trip_set[lfc_pkg::FLAG_VMON])
	);

	// Flash-time monitor; short deglitch so brief droops are ignored
	lfc_trip_qualify #(
		.CNT_W(CNT_W),
		.HOLD_CYC(DEGLITCH_CYC)
	) u_vflash_qual (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.arm(vflash_arm),
		.below(supply_below_flash),
		.trip(trip_set[lfc_pkg::FLAG_VFLASH])
	);

	assign trip_any = |trip_set;

	// A read of the flags address empties every fault flag not set in the same cycle
	assign flags_clr = reg_rd && (reg_addr == lfc_pkg::ADDR_FLAGS);

	lfc_fault_flags #(
		.N(lfc_pkg::NUM_FLAGS)
	) u_flags (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.set(trip_set),
		.clr(flags_clr),
		.flags(fault_flags)
	);

	// Capture rides the same pulse as the flag set, so both land together;
	// nothing else, host writes included, can touch it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			last_flash_capture_reg <= lfc_pkg::LAST_FLASH_RST;
		end else if (trip_any) begin
			last_flash_capture_reg <= flash_current_select_reg;
		end
	end

	assign last_flash_capture = last_flash_capture_reg;

	// Flag-write event to the flags register logic, aligned with the update
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			flag_write_reg <= 1'b0;
		end else begin
			flag_write_reg <= trip_any;
		end
	end

	assign flag_write = flag_write_reg;

	// Read mux; unmapped addresses, the flags address included, answer zero
	always_comb begin
		rdata_next = lfc_pkg::RDATA_ZERO;
		hit_next = 1'b1;
		case (reg_addr)
			lfc_pkg::ADDR_SUPPLY_MON: begin
				rdata_next = supply_monitor_config_reg;
			end
			lfc_pkg::ADDR_LAST_FLASH: begin
				rdata_next = last_flash_capture_reg;
			end
			lfc_pkg::ADDR_TORCH: begin
				rdata_next = {2'h0, torch_current_select_reg};
			end
			lfc_pkg::ADDR_FLASH: begin
				rdata_next = flash_current_select_reg;
			end
			default: begin
				hit_next = 1'b0;
			end
		endcase
	end

	// Read data registered one cycle after the strobe, held until next read
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= lfc_pkg::RDATA_ZERO;
			hit_reg <= 1'b0;
		end else if (reg_rd) begin
			rdata_reg <= rdata_next;
			hit_reg <= hit_next;
		end
	end

	// Read acknowledge pulse
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= reg_rd;
		end
	end

	assign reg_rdata = rdata_reg;
	assign reg_hit = hit_reg;
	assign reg_rd_ack = ack_reg;
endmodule

// file: logic/lfc_fault_flags.sv
// Sticky fault flags, cleared together by a read of the flags register
`timescale 1ns/1ps
module lfc_fault_flags #(
	parameter int N = 3
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [N-1:0] set,
	input wire logic clr,
	output logic [N-1:0] flags
);
	initial begin
		if (N < 1) begin
			$error("lfc_fault_flags: N must be positive");
		end
	end

	// Set beats clear so a trip landing on the read is not lost
	for (genvar i = 0; i < N; i++) begin : g_flag
		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				flags[i] <= 1'b0;
			end else if (set[i]) begin
				flags[i] <= 1'b1;
			end else if (clr) begin
				flags[i] <= 1'b0;
			end
		end
	end
endmodule

// file: logic/lfc_trip_qualify.sv
// Comparator trip qualifier: fires once after the input stays low long enough
`timescale 1ns/1ps
module lfc_trip_qualify #(
	parameter int CNT_W = 16,
	parameter int HOLD_CYC = 1600
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic arm,
	input wire logic below,
	output logic trip
);
	lfc_pkg::lfc_qual_state_t state_reg;
	logic [CNT_W-1:0] cnt_reg;

	// Refuse counts the counter cannot hold
	initial begin
		if (HOLD_CYC < 1 || HOLD_CYC > (2 ** CNT_W)) begin
			$error("lfc_trip_qualify: HOLD_CYC out of range");
		end
	end

	// Count while low; one pulse at the end, then wait for recovery so a
	// long brown-out does not keep reloading the capture register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= lfc_pkg::QS_IDLE;
			cnt_reg <= '0;
			trip <= 1'b0;
		end else begin
			trip <= 1'b0;
			case (state_reg)
				lfc_pkg::QS_IDLE: begin
					cnt_reg <= '0;
					if (arm && below) begin
						state_reg <= lfc_pkg::QS_COUNT;
					end
				end
				lfc_pkg::QS_COUNT: begin
					if (!arm || !below) begin
						state_reg <= lfc_pkg::QS_IDLE;
					end else if (cnt_reg == CNT_W'(HOLD_CYC - 1)) begin
						trip <= 1'b1;
						state_reg <= lfc_pkg::QS_HELD;
					end else begin
						cnt_reg <= cnt_reg + 1'b1;
					end
				end
				lfc_pkg::QS_HELD: begin
					if (!arm || !below) begin
						state_reg <= lfc_pkg::QS_IDLE;
					end
				end
				default: begin
					state_reg <= lfc_pkg::QS_IDLE;
				end
			endcase
		end
	end
endmodule

// file: test/lfc_config_regs_asserts.sv
// Assertion checker for the flash driver configuration registers
`timescale 1ns/1ps
module lfc_config_regs_asserts #(
	parameter int TRIP_DELAY_CYC = 50000,
	parameter int DEGLITCH_CYC = 1600
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rd_ack,
	input wire logic reg_hit,
	input wire logic thermistor_sense_pin,
	input wire logic ntc_mode_en,
	input wire logic supply_below_mon,
	input wire logic supply_below_flash,
	input wire logic supply_mon_en,
	input wire logic [1:0] supply_monitor_level,
	input wire logic flash_mon_en,
	input wire logic [1:0] flash_monitor_level,
	input wire logic [2:0] led1_torch_code,
	input wire logic [2:0] led2_torch_code,
	input wire logic [3:0] led1_flash_code,
	input wire logic [3:0] led2_flash_code,
	input wire logic [7:0] last_flash_capture,
	input wire logic [2:0] fault_flags,
	input wire logic flag_write
);
	localparam int LIM [3] = '{TRIP_DELAY_CYC, TRIP_DELAY_CYC, DEGLITCH_CYC};
	logic [2:0] src;
	logic [2:0] seen;
	logic [16:0] run [3];

	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// Qualified comparator levels, in fault flag order
	assign src = {flash_mon_en & supply_below_flash, supply_mon_en & supply_below_mon,
		ntc_mode_en & thermistor_sense_pin};

	// Run length of each level; saturates so a long hold cannot wrap
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			seen <= 3'h0;
			run <= '{3{17'h0}};
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (!src[i]) begin
					run[i] <= 17'h0;
				end else if (run[i] <= 17'(LIM[i] + 8)) begin
					run[i] <= run[i] + 17'h1;
				end
				seen[i] <= src[i] & (seen[i] | fault_flags[i]);
			end
		end
	end

	sequence s_rd(logic [7:0] a);
		reg_rd && reg_addr == a;
	endsequence

	sequence s_wr(logic [7:0] a);
		reg_wr && reg_addr == a;
	endsequence

	AST_SM_WR: assert property (s_wr(lfc_pkg::ADDR_SUPPLY_MON) |=>
		{flash_monitor_level, flash_mon_en, supply_monitor_level, supply_mon_en}
		== $past(reg_wdata[5:0])) else $error("supply monitor write lost");
	AST_TORCH_WR: assert property (s_wr(lfc_pkg::ADDR_TORCH) |=>
		{led2_torch_code, led1_torch_code} == $past(reg_wdata[5:0])) else $error("torch write lost");
	AST_FLASH_WR: assert property (s_wr(lfc_pkg::ADDR_FLASH) |=>
		{led2_flash_code, led1_flash_code} == $past(reg_wdata)) else $error("flash write lost");
	AST_CAPTURE: assert property (flag_write |->
		last_flash_capture == {$past(led2_flash_code), $past(led1_flash_code)})
		else $error("capture differs from flash codes");
	AST_CAP_HOLD: assert property (!flag_write |-> $stable(last_flash_capture))
		else $error("capture changed without a trip");
	AST_FLAG_SAME: assert property (|(fault_flags & ~$past(fault_flags)) |-> flag_write)
		else $error("flag set without flag write");
	AST_CLEAR: assert property (s_rd(lfc_pkg::ADDR_FLAGS) |=> fault_flags == 3'h0 || flag_write)
		else $error("flags survived a flags read");
	// Run length one cycle back, so a level dropping right after the trip is no false alarm
	AST_NTC_EARLY: assert property ($rose(fault_flags[0]) |-> $past(run[0]) >= LIM[0])
		else $error("thermistor flag too early");
	AST_VM_EARLY: assert property ($rose(fault_flags[1]) |-> $past(run[1]) >= LIM[1])
		else $error("supply monitor flag too early");
	AST_FL_EARLY: assert property ($rose(fault_flags[2]) |-> $past(run[2]) >= LIM[2])
		else $error("flash-time flag too early");
	AST_VM_LATE: assert property (run[1] == LIM[1] + 5 |-> seen[1] || fault_flags[1])
		else $error("supply monitor trip missing");
	AST_NTC_LATE: assert property (run[0] == LIM[0] + 5 |-> seen[0] || fault_flags[0])
		else $error("thermistor trip missing");
	AST_FL_LATE: assert property (run[2] == LIM[2] + 5 |-> seen[2] || fault_flags[2])
		else $error("flash-time trip missing");
endmodule

bind lfc_config_regs lfc_config_regs_asserts #(.TRIP_DELAY_CYC(TRIP_DELAY_CYC),
	.DEGLITCH_CYC(DEGLITCH_CYC)) i_chk (.*);

// file: test/lfc_host_model.sv
// Host processor model driving the register port
`timescale 1ns/1ps
module lfc_host_model (
	input wire logic clk_sys,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rd_ack,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	// Idle port at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// One-cycle write strobe; data inverted afterwards so stale data never looks valid
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask

	// One-cycle read strobe, address held until the acknowledge is seen
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		int i;
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		for (i = 0; i < 4 && reg_rd_ack !== 1'b1; i++) begin
			@(posedge clk_sys);
		end
		d = reg_rdata;
		if (i == 4) begin
			testbench.errors++;
			testbench.summarize();
		end
	endtask
endmodule

// file: test/testbench.sv
// Self-checking bench for the flash driver configuration registers
`timescale 1ns/1ps
module testbench;
	localparam int TRIP = 8;
	localparam int DGL = 2;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, last_flash_capture, rd;
	logic reg_wr, reg_rd, reg_rd_ack, reg_hit, flag_write, supply_mon_en, flash_mon_en;
	logic thermistor_sense_pin = 1'b0;
	logic ntc_mode_en = 1'b0;
	logic supply_below_mon = 1'b0;
	logic supply_below_flash = 1'b0;
	logic [1:0] supply_monitor_level, flash_monitor_level;
	logic [2:0] led1_torch_code, led2_torch_code, fault_flags;
	logic [3:0] led1_flash_code, led2_flash_code;
	int errors = 0;
	int n_checks = 0;

	// Short trip counts keep the run brief; they differ so a swap shows
	always #2.5 clk_sys = ~clk_sys;
	lfc_config_regs #(.TRIP_DELAY_CYC(TRIP), .DEGLITCH_CYC(DGL)) i_dut (.*);
	lfc_host_model i_host (.*);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("errors %0d, checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		i_host.read_reg(a, rd);
		check(rd, e);
	endtask

	task automatic set_cmp(input int s, input logic v);
		case (s)
			0: thermistor_sense_pin <= v;
			1: supply_below_mon <= v;
			default: supply_below_flash <= v;
		endcase
	endtask

	// Raise one level for hold cycles (0 = throughout) and time the capture
	task automatic trip(input int s, input int n, input int hold, input bit fire,
		input logic [7:0] cap);
		int k;
		k = 0;
		set_cmp(s, 1'b1);
		for (int i = 1; i <= n + 6; i++) begin
			@(posedge clk_sys);
			if (i == hold) begin
				set_cmp(s, 1'b0);
			end
			if (flag_write === 1'b1 && k == 0) begin
				k = i;
				check(fault_flags, 8'(1 << s));
				check(last_flash_capture, cap);
			end
		end
		set_cmp(s, 1'b0);
		check(fire ? (k >= n + 2 && k <= n + 4) : (k == 0), 1'b1);
		rdc(lfc_pkg::ADDR_FLAGS, 8'h00);
		check(fault_flags, 3'h0);
	endtask

	initial begin
		logic [7:0] v;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		// Reset contents, a refused capture write and an unmapped read
		rdc(lfc_pkg::ADDR_SUPPLY_MON, 8'h00);
		rdc(lfc_pkg::ADDR_FLASH, 8'hdd);
		check(reg_hit, 1'b1);
		rdc(lfc_pkg::ADDR_TORCH, 8'h12);
		i_host.write_reg(lfc_pkg::ADDR_LAST_FLASH, 8'hff);
		rdc(lfc_pkg::ADDR_LAST_FLASH, 8'h00);
		rdc(8'h55, 8'h00);
		check(reg_hit, 1'b0);
		// Every threshold code on both monitors, unused top bits written high
		for (int t = 0; t < 4; t++) begin
			v = {2'h3, 2'(t), 1'b1, 2'(3 - t), t[0]};
			i_host.write_reg(lfc_pkg::ADDR_SUPPLY_MON, v);
			rdc(lfc_pkg::ADDR_SUPPLY_MON, v & 8'h3f);
			check({supply_mon_en, supply_monitor_level}, {t[0], 2'(3 - t)});
			check({flash_mon_en, flash_monitor_level}, {1'b1, 2'(t)});
		end
		// Field placement of the LED current codes
		i_host.write_reg(lfc_pkg::ADDR_TORCH, 8'hcb);
		rdc(lfc_pkg::ADDR_TORCH, 8'h0b);
		check({led2_torch_code, led1_torch_code}, 6'h0b);
		i_host.write_reg(lfc_pkg::ADDR_FLASH, 8'h5a);
		// The write lands on the edge the task returns at; look once it has settled
		@(negedge clk_sys);
		check({led2_flash_code, led1_flash_code}, 8'h5a);
		// Each source fires after its own count; short holds are rejected on the thermistor and flash-time sources
		i_host.write_reg(lfc_pkg::ADDR_SUPPLY_MON, 8'h09);
		ntc_mode_en <= 1'b1;
		trip(0, TRIP, 0, 1'b1, 8'h5a);
		trip(0, TRIP, TRIP - 1, 1'b0, 8'h5a);
		i_host.write_reg(lfc_pkg::ADDR_FLASH, 8'h3c);
		trip(1, TRIP, 0, 1'b1, 8'h3c);
		i_host.write_reg(lfc_pkg::ADDR_FLASH, 8'hf0);
		trip(2, DGL, 0, 1'b1, 8'hf0);
		trip(2, DGL, DGL - 1, 1'b0, 8'hf0);
		// Disabled sources never capture, so the last capture stays
		i_host.write_reg(lfc_pkg::ADDR_SUPPLY_MON, 8'h36);
		ntc_mode_en <= 1'b0;
		for (int s = 0; s < 3; s++) begin
			trip(s, TRIP, 0, 1'b0, 8'h00);
		end
		check(last_flash_capture, 8'hf0);
		summarize();
	end
endmodule
